// File: rtl/wrx_ctrl.sv
// Module: receive control, status and byte count limit logic of the radio attach unit
//
// Behaviour
// - Limit high register holds upper four bits
// - Limit low register holds lower eight bits
// - One shared 12-bit running byte counter
// - Transmit limit event when unmasked
// - Receive limit event when unmasked
// - Transmit count after delimiter, excluding CRC
// - Receive count every byte after delimiter
// - Limit event changes nothing else
// - Control bit 7 holds receive reset
// - Receive reset leaves queue untouched
// - Control bit 6 holds queue reset
// - Control bit 0 starts receive machine
// - Service request independent of start bit
// - Start acts on rising transition only
// - Clearing start never aborts reception
// - CRC32 good sets bit 7, latches count
// - CRC8 good sets bit 6, latches count
// - Overflow flag cleared only by queue reset or whole-chip soft reset
// - Bits 4-1 show queue fill level
// - Busy from start until receive reset
// - Control and status reset to zero
//
// The register addresses and the plain strobed port are this design's own decisions.
`default_nettype none
module wrx_ctrl
    import wrx_pkg::*;
#(
    parameter int QUEUE_DEPTH = 15,
    parameter int DRQ_LEVEL = 1
)
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic whole_chip_soft_reset,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata_ff,
    // Receive front end
    input wire logic rx_sfd_seen,
    input wire logic rx_byte_stb,
    input wire logic rx_frame_end,
    input wire logic crc32_good,
    input wire logic crc8_good,
    input wire logic rx_queue_pop,
    // Transmit front end
    input wire logic tx_sfd_sent,
    input wire logic tx_byte_stb,
    input wire logic tx_byte_is_crc,
    input wire logic tx_frame_end,
    // Outputs
    output logic tx_limit_irq_ff,
    output logic rx_limit_irq_ff,
    output logic rx_abort_reset_ff,
    output logic rx_queue_clear_ff,
    output logic rx_start_pulse_ff,
    output logic rx_active_flag_ff,
    output logic dma_service_request_ff
);
    // ****************************************
    // Registers and internal state
    // ****************************************
    logic [7:0] limit_low_ff;
    logic [3:0] limit_high_ff;
    logic abort_ff;
    logic qclr_ff;
    logic go_ff;
    logic [1:0] mask_ff;
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] crc32_count_ff;
    logic [CNT_W-1:0] crc8_count_ff;
    logic crc32_ok_ff;
    logic crc8_ok_ff;
    logic limit_hit_ff;
    wrx_dir_t dir_ff;
    wrx_dir_t nxt_dir;
    logic [FILL_W-1:0] fill_level;
    logic overflow;
    logic soft_rx_clear;
    logic count_stb;
    logic [CNT_W-1:0] nxt_count;
    logic [CNT_W-1:0] limit_val;
    logic go_rise;
    logic [DATA_W-1:0] nxt_rdata;

    function automatic logic wr_hit(input logic [3:0] off);
        wr_hit = reg_wr && (reg_addr == off);
    endfunction

    function automatic logic [7:0] hi_nib(input logic [CNT_W-1:0] v);
        hi_nib = {4'h0, v[11:8]};
    endfunction

    assign limit_val = {limit_high_ff, limit_low_ff};
    assign soft_rx_clear = whole_chip_soft_reset || abort_ff;
    // Written out in full: a continuous assign does not wake on signals read only inside a function
    assign go_rise = reg_wr && (reg_addr == OFF_RECEIVER_CONTROL) && reg_wdata[CTL_GO_BIT] && !go_ff;

    // ****************************************
    // Register writes
    // ****************************************
    // Reserved bits are simply not stored
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            limit_low_ff <= RST_LIMIT_LOW;
            limit_high_ff <= RST_LIMIT_HIGH;
            mask_ff <= RST_MASK;
        end
        else if (clk_en)
        begin
            if (wr_hit(OFF_LIMIT_LOW))
                limit_low_ff <= reg_wdata;
            if (wr_hit(OFF_BYTE_LIMIT_HIGH))
                limit_high_ff <= reg_wdata[3:0];
            if (wr_hit(OFF_IRQ_MASK))
                mask_ff <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            abort_ff <= RST_CONTROL[CTL_ABORT_BIT];
            qclr_ff <= RST_CONTROL[CTL_QCLR_BIT];
            go_ff <= RST_CONTROL[CTL_GO_BIT];
        end
        else if (clk_en)
        begin
            if (whole_chip_soft_reset)
            begin
                abort_ff <= 1'b0;
                qclr_ff <= 1'b0;
                go_ff <= 1'b0;
            end
            else if (wr_hit(OFF_RECEIVER_CONTROL))
            begin
                abort_ff <= reg_wdata[CTL_ABORT_BIT];
                qclr_ff <= reg_wdata[CTL_QCLR_BIT];
                go_ff <= reg_wdata[CTL_GO_BIT];
            end
        end
    end

    // ****************************************
    // Receive start and busy
    // ****************************************
    // Start pulse only on a 0 to 1 write; clearing go does not abort
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_start_pulse_ff <= 1'b0;
            rx_active_flag_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            rx_start_pulse_ff <= go_rise && !soft_rx_clear;
            if (soft_rx_clear)
                rx_active_flag_ff <= 1'b0;
            else if (go_rise)
                rx_active_flag_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_abort_reset_ff <= 1'b0;
            rx_queue_clear_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            rx_abort_reset_ff <= soft_rx_clear;
            rx_queue_clear_ff <= qclr_ff || whole_chip_soft_reset;
        end
    end

    // ****************************************
    // Direction and shared byte counter
    // ****************************************
    always_comb
    begin
        nxt_dir = dir_ff;
        case (dir_ff)
            WRX_IDLE:
            begin
                if (rx_sfd_seen && rx_active_flag_ff)
                    nxt_dir = WRX_RX;
                else if (tx_sfd_sent)
                    nxt_dir = WRX_TX;
            end
            WRX_RX:
            begin
                if (rx_frame_end)
                    nxt_dir = WRX_IDLE;
            end
            WRX_TX:
            begin
                if (tx_frame_end)
                    nxt_dir = WRX_IDLE;
            end
            default:
                nxt_dir = WRX_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            dir_ff <= WRX_IDLE;
        else if (clk_en)
        begin
            if (soft_rx_clear && dir_ff == WRX_RX)
                dir_ff <= WRX_IDLE;
            else
                dir_ff <= nxt_dir;
        end
    end

    // Bytes before the delimiter are never seen: counting starts in RX or TX
    assign count_stb = (dir_ff == WRX_RX && rx_byte_stb)
        || (dir_ff == WRX_TX && tx_byte_stb && !tx_byte_is_crc);
    assign nxt_count = count_ff + CNT_W'(1);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            count_ff <= RST_COUNT;
        else if (clk_en)
        begin
            if (dir_ff == WRX_IDLE || (soft_rx_clear && dir_ff == WRX_RX))
                count_ff <= RST_COUNT;
            else if (count_stb)
                count_ff <= nxt_count;
        end
    end

    // ****************************************
    // Limit event, once per frame
    // ****************************************
    // Pure event: nothing here feeds back into direction or queue
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            limit_hit_ff <= 1'b0;
            tx_limit_irq_ff <= 1'b0;
            rx_limit_irq_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            tx_limit_irq_ff <= 1'b0;
            rx_limit_irq_ff <= 1'b0;
            if (dir_ff == WRX_IDLE)
                limit_hit_ff <= 1'b0;
            else if (count_stb && nxt_count == limit_val && !limit_hit_ff)
            begin
                limit_hit_ff <= 1'b1;
                tx_limit_irq_ff <= (dir_ff == WRX_TX) && mask_ff[MSK_TX_BIT];
                rx_limit_irq_ff <= (dir_ff == WRX_RX) && mask_ff[MSK_RX_BIT];
            end
        end
    end

    // ****************************************
    // CRC good flags and count latches
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            crc32_ok_ff <= 1'b0;
            crc8_ok_ff <= 1'b0;
            crc32_count_ff <= RST_COUNT;
            crc8_count_ff <= RST_COUNT;
        end
        else if (clk_en)
        begin
            // Set wins over a same-cycle start clear
            if (crc32_good)
            begin
                crc32_ok_ff <= 1'b1;
                crc32_count_ff <= count_ff;
            end
            else if (go_rise || soft_rx_clear)
                crc32_ok_ff <= 1'b0;
            if (crc8_good)
            begin
                crc8_ok_ff <= 1'b1;
                crc8_count_ff <= count_ff;
            end
            else if (go_rise || soft_rx_clear)
                crc8_ok_ff <= 1'b0;
        end
    end

    // ****************************************
    // Receive queue level and service request
    // ****************************************
    wrx_fill #(
        .DEPTH(QUEUE_DEPTH),
        .FW(FILL_W)
    ) u_fill (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .queue_clear(rx_queue_clear_ff),
        .push(dir_ff == WRX_RX && rx_byte_stb),
        .pop(rx_queue_pop),
        .level_ff(fill_level),
        .overflow_ff(overflow)
    );

    // Go bit deliberately absent from this term
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            dma_service_request_ff <= 1'b0;
        else if (clk_en)
            dma_service_request_ff <= (fill_level >= FILL_W'(DRQ_LEVEL));
    end

    // ****************************************
    // Register reads
    // ****************************************
    always_comb
    begin
        case (reg_addr)
            OFF_LIMIT_LOW: nxt_rdata = limit_low_ff;
            OFF_BYTE_LIMIT_HIGH: nxt_rdata = {4'h0, limit_high_ff};
            OFF_RECEIVER_CONTROL: nxt_rdata = {abort_ff, qclr_ff, 5'h00, go_ff};
            OFF_RECEIVER_STATUS: nxt_rdata = {crc32_ok_ff, crc8_ok_ff, overflow,
                fill_level, rx_active_flag_ff};
            OFF_IRQ_MASK: nxt_rdata = {6'h00, mask_ff};
            OFF_BYTE_COUNT_LOW: nxt_rdata = count_ff[7:0];
            OFF_BYTE_COUNT_HIGH: nxt_rdata = hi_nib(count_ff);
            OFF_CRC32_COUNT_LOW: nxt_rdata = crc32_count_ff[7:0];
            OFF_CRC32_COUNT_HIGH: nxt_rdata = hi_nib(crc32_count_ff);
            OFF_CRC8_COUNT_LOW: nxt_rdata = crc8_count_ff[7:0];
            OFF_CRC8_COUNT_HIGH: nxt_rdata = hi_nib(crc8_count_ff);
            default: nxt_rdata = RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata_ff <= 8'h00;
        else if (clk_en)
        begin
            if (reg_rd)
                reg_rdata_ff <= nxt_rdata;
            else
                reg_rdata_ff <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// File: rtl/wrx_fill.sv
// Module: receive queue fill counter with overflow tracking
`default_nettype none
module wrx_fill
    import wrx_pkg::*;
#(
    parameter int DEPTH = 15,
    parameter int FW = 4
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic queue_clear,
    // Queue events
    input wire logic push,
    input wire logic pop,
    // Status
    output logic [FW-1:0] level_ff,
    output logic overflow_ff
);
    localparam logic [FW-1:0] DEPTH_V = FW'(DEPTH);
    logic is_full;
    logic is_empty;
    logic [FW-1:0] nxt_level;
    logic push_ok;
    logic pop_ok;
    assign is_full = (level_ff == DEPTH_V);
    assign is_empty = (level_ff == RST_FILL);
    // A pop frees the slot that a push into a full queue then takes
    assign push_ok = push && (!is_full || pop);
    assign pop_ok = pop && !is_empty;

    always_comb
    begin
        nxt_level = level_ff;
        if (push_ok && !pop_ok)
            nxt_level = level_ff + FW'(1);
        else if (pop_ok && !push_ok)
            nxt_level = level_ff - FW'(1);
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            level_ff <= RST_FILL;
        else if (clk_en)
        begin
            if (queue_clear)
                level_ff <= RST_FILL;
            else
                level_ff <= nxt_level;
        end
    end

    // Push into a full queue without a pop is lost data
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            overflow_ff <= 1'b0;
        else if (clk_en)
        begin
            // Set wins over a same-cycle queue clear
            if (push && is_full && !pop)
                overflow_ff <= 1'b1;
            else if (queue_clear)
                overflow_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: rtl/wrx_pkg.sv
// Package: register map, field positions and reset values for the receive control block
`default_nettype none
package wrx_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CNT_W = 12;
    localparam int FILL_W = 4;
    // Register offsets
    localparam logic [3:0] OFF_LIMIT_LOW = 4'h0;
    localparam logic [3:0] OFF_BYTE_LIMIT_HIGH = 4'h1;
    localparam logic [3:0] OFF_RECEIVER_CONTROL = 4'h2;
    localparam logic [3:0] OFF_RECEIVER_STATUS = 4'h3;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h4;
    localparam logic [3:0] OFF_BYTE_COUNT_LOW = 4'h5;
    localparam logic [3:0] OFF_BYTE_COUNT_HIGH = 4'h6;
    localparam logic [3:0] OFF_CRC32_COUNT_LOW = 4'h7;
    localparam logic [3:0] OFF_CRC32_COUNT_HIGH = 4'h8;
    localparam logic [3:0] OFF_CRC8_COUNT_LOW = 4'h9;
    localparam logic [3:0] OFF_CRC8_COUNT_HIGH = 4'ha;
    // Control field positions
    localparam int CTL_ABORT_BIT = 7;
    localparam int CTL_QCLR_BIT = 6;
    localparam int CTL_GO_BIT = 0;
    // Status field positions
    localparam int ST_CRC32_BIT = 7;
    localparam int ST_CRC8_BIT = 6;
    localparam int ST_OVF_BIT = 5;
    localparam int ST_FILL_LSB = 1;
    localparam int ST_BUSY_BIT = 0;
    // Mask field positions
    localparam int MSK_TX_BIT = 0;
    localparam int MSK_RX_BIT = 1;
    // Reset values
    localparam logic [7:0] RST_LIMIT_LOW = 8'h00;
    localparam logic [3:0] RST_LIMIT_HIGH = 4'h0;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [1:0] RST_MASK = 2'h0;
    localparam logic [11:0] RST_COUNT = 12'h000;
    localparam logic [3:0] RST_FILL = 4'h0;
    localparam logic [3:0] FILL_FULL = 4'hf;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    typedef enum logic [1:0] {WRX_IDLE, WRX_RX, WRX_TX} wrx_dir_t;
endpackage
`default_nettype wire

// File: tb/testbench.sv
// Testbench: register and frame scenarios for the receive control block
`default_nettype none
module testbench
    import wrx_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, clk_en, soft_rst, reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_ff;
    wire logic rx_sfd_seen, rx_byte_stb, rx_frame_end, crc32_good, crc8_good, rx_queue_pop;
    wire logic tx_sfd_sent, tx_byte_stb, tx_byte_is_crc, tx_frame_end;
    logic tx_limit_irq_ff, rx_limit_irq_ff, rx_abort_reset_ff, rx_queue_clear_ff;
    logic rx_start_pulse_ff, rx_active_flag_ff, dma_service_request_ff;
    int errors = 0;
    int n_tests = 0;
    int n_rx = 0;
    int n_tx = 0;
    wrx_ctrl u_wrx_ctrl (.clk, .sys_rst, .clk_en, .whole_chip_soft_reset(soft_rst), .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata_ff, .rx_sfd_seen, .rx_byte_stb, .rx_frame_end, .crc32_good, .crc8_good,
        .rx_queue_pop, .tx_sfd_sent, .tx_byte_stb, .tx_byte_is_crc, .tx_frame_end, .tx_limit_irq_ff,
        .rx_limit_irq_ff, .rx_abort_reset_ff, .rx_queue_clear_ff, .rx_start_pulse_ff, .rx_active_flag_ff,
        .dma_service_request_ff);
    wrx_radio_model u_wrx_radio_model (.clk, .rx_sfd_seen, .rx_byte_stb, .rx_frame_end, .crc32_good,
        .crc8_good, .rx_queue_pop, .tx_sfd_sent, .tx_byte_stb, .tx_byte_is_crc, .tx_frame_end);
    // ************************************************
    // Access and report tasks
    // ************************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk) reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk) reg_rd <= 1'b0;
        #1 chk("rdata", e, reg_rdata_ff);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (rx_limit_irq_ff === 1'b1) n_rx++;
        if (tx_limit_irq_ff === 1'b1) n_tx++;
    end
    // Frames are fixed length, so a hang can only come from a stuck simulation
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("unexpected timeout");
        test_done;
    end
    // ************************************************
    // Scenarios
    // ************************************************
    initial
    begin
        {sys_rst, clk_en, soft_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h3, 3'h0, 4'h0, 8'h00};
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd(OFF_RECEIVER_CONTROL, 8'h00);
        rd(OFF_RECEIVER_STATUS, 8'h00);
        rd(OFF_BYTE_LIMIT_HIGH, 8'h00);
        wr(OFF_BYTE_LIMIT_HIGH, 8'h0a);
        rd(OFF_BYTE_LIMIT_HIGH, 8'h0a);
        wr(OFF_BYTE_LIMIT_HIGH, 8'h00);
        wr(OFF_LIMIT_LOW, 8'h03);
        rd(OFF_LIMIT_LOW, 8'h03);
        wr(4'hf, 8'h55);
        rd(4'hf, 8'h00);
        wr(OFF_IRQ_MASK, 8'h02);
        wr(OFF_RECEIVER_CONTROL, 8'h01);
        chk("start", 8'h01, rx_start_pulse_ff);
        wr(OFF_RECEIVER_CONTROL, 8'h00);
        u_wrx_radio_model.rx_frame(5, 2'b01);
        chk("rx events", 8'h01, n_rx[7:0]);
        rd(OFF_CRC32_COUNT_LOW, 8'h05);
        rd(OFF_RECEIVER_STATUS, 8'h8b);
        chk("service", 8'h01, dma_service_request_ff);
        u_wrx_radio_model.pop(2);
        rd(OFF_RECEIVER_STATUS, 8'h87);
        wr(OFF_IRQ_MASK, 8'h00);
        u_wrx_radio_model.rx_frame(4, 2'b10);
        chk("rx events", 8'h01, n_rx[7:0]);
        rd(OFF_CRC8_COUNT_LOW, 8'h04);
        rd(OFF_RECEIVER_STATUS, 8'hcf);
        u_wrx_radio_model.rx_frame(10, 2'b00);
        rd(OFF_RECEIVER_STATUS, 8'hff);
        wr(OFF_RECEIVER_CONTROL, 8'h80);
        @(posedge clk) #1 chk("abort", 8'h01, rx_abort_reset_ff);
        rd(OFF_RECEIVER_STATUS, 8'h3e);
        wr(OFF_RECEIVER_CONTROL, 8'h00);
        @(posedge clk) #1 chk("abort", 8'h00, rx_abort_reset_ff);
        wr(OFF_RECEIVER_CONTROL, 8'h40);
        @(posedge clk) #1 chk("queue clear", 8'h01, rx_queue_clear_ff);
        wr(OFF_RECEIVER_CONTROL, 8'h00);
        rd(OFF_RECEIVER_STATUS, 8'h00);
        chk("service", 8'h00, dma_service_request_ff);
        wr(OFF_RECEIVER_CONTROL, 8'h01);
        wr(OFF_RECEIVER_CONTROL, 8'h01);
        chk("start", 8'h00, rx_start_pulse_ff);
        wr(OFF_IRQ_MASK, 8'h01);
        wr(OFF_BYTE_LIMIT_HIGH, 8'h01);
        u_wrx_radio_model.tx_frame(259, 2);
        chk("tx events", 8'h01, n_tx[7:0]);
        wr(OFF_BYTE_LIMIT_HIGH, 8'h00);
        wr(OFF_LIMIT_LOW, 8'h04);
        u_wrx_radio_model.tx_frame(3, 2);
        chk("tx events", 8'h01, n_tx[7:0]);
        u_wrx_radio_model.tx_frame(4, 2);
        chk("tx events", 8'h02, n_tx[7:0]);
        // Write with the enable low must be lost
        @(posedge clk) clk_en <= 1'b0;
        wr(OFF_LIMIT_LOW, 8'h77);
        @(posedge clk) clk_en <= 1'b1;
        rd(OFF_LIMIT_LOW, 8'h04);
        chk("busy", 8'h01, rx_active_flag_ff);
        @(posedge clk) soft_rst <= 1'b1;
        @(posedge clk) soft_rst <= 1'b0;
        #1 chk("busy", 8'h00, rx_active_flag_ff);
        test_done;
    end
endmodule
`default_nettype wire

// File: tb/wrx_ctrl_properties.sv
// Checker: port-level properties of the receive control block
`default_nettype none
module wrx_ctrl_properties
    import wrx_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic whole_chip_soft_reset,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    // Front end
    input wire logic rx_byte_stb,
    input wire logic tx_byte_stb,
    input wire logic tx_byte_is_crc,
    // Outputs
    input wire logic tx_limit_irq_ff,
    input wire logic rx_limit_irq_ff,
    input wire logic rx_abort_reset_ff,
    input wire logic rx_queue_clear_ff,
    input wire logic rx_start_pulse_ff,
    input wire logic rx_active_flag_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ************************************************
    // Properties
    // ************************************************
    sequence ctl_wr;
        reg_wr && reg_addr == OFF_RECEIVER_CONTROL && !whole_chip_soft_reset;
    endsequence
    sequence go_rise;
        reg_wr && reg_addr == OFF_RECEIVER_CONTROL && reg_wdata[CTL_GO_BIT] ##1 rx_start_pulse_ff;
    endsequence
    // Control bit lands one edge after the write, the output one edge later
    abort_level_a: assert property (ctl_wr ##1 !whole_chip_soft_reset
        |=> rx_abort_reset_ff == $past(reg_wdata[CTL_ABORT_BIT], 2))
        else $error("abort level differs from written bit");
    qclr_level_a: assert property (ctl_wr ##1 !whole_chip_soft_reset
        |=> rx_queue_clear_ff == $past(reg_wdata[CTL_QCLR_BIT], 2))
        else $error("queue clear level differs from written bit");
    go_cause_a: assert property (rx_start_pulse_ff |-> $past(reg_wr && reg_addr == OFF_RECEIVER_CONTROL))
        else $error("start pulse without control write");
    start_pulse_a: assert property (go_rise |-> rx_active_flag_ff ##1 !rx_start_pulse_ff)
        else $error("start pulse not single or busy not set");
    busy_fall_a: assert property ($fell(rx_active_flag_ff) |-> rx_abort_reset_ff || $past(whole_chip_soft_reset))
        else $error("busy dropped without a reset");
    abort_busy_a: assert property (rx_abort_reset_ff |-> !rx_active_flag_ff)
        else $error("busy stays during receive reset");
    rx_cause_a: assert property (rx_limit_irq_ff |-> $past(rx_byte_stb))
        else $error("rx limit event without a byte");
    tx_cause_a: assert property (tx_limit_irq_ff |-> $past(tx_byte_stb && !tx_byte_is_crc))
        else $error("tx limit event without a data byte");
    irq_once_a: assert property (tx_limit_irq_ff |=> !tx_limit_irq_ff [*2])
        else $error("tx limit event repeated");
endmodule

bind wrx_ctrl wrx_ctrl_properties u_props (.clk(clk), .sys_rst(sys_rst),
    .whole_chip_soft_reset(whole_chip_soft_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .rx_byte_stb(rx_byte_stb), .tx_byte_stb(tx_byte_stb), .tx_byte_is_crc(tx_byte_is_crc),
    .tx_limit_irq_ff(tx_limit_irq_ff), .rx_limit_irq_ff(rx_limit_irq_ff), .rx_abort_reset_ff(rx_abort_reset_ff),
    .rx_queue_clear_ff(rx_queue_clear_ff), .rx_start_pulse_ff(rx_start_pulse_ff),
    .rx_active_flag_ff(rx_active_flag_ff));
`default_nettype wire

// File: tb/wrx_radio_model.sv
// Partner model: radio front end that frames receive and transmit traffic
`default_nettype none
module wrx_radio_model
(
    // Clock
    input wire logic clk,
    // Front end pulses
    output logic rx_sfd_seen,
    output logic rx_byte_stb,
    output logic rx_frame_end,
    output logic crc32_good,
    output logic crc8_good,
    output logic rx_queue_pop,
    output logic tx_sfd_sent,
    output logic tx_byte_stb,
    output logic tx_byte_is_crc,
    output logic tx_frame_end
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {rx_sfd_seen, rx_byte_stb, rx_frame_end, crc32_good, crc8_good, rx_queue_pop} = '0;
    initial {tx_sfd_sent, tx_byte_stb, tx_byte_is_crc, tx_frame_end} = '0;
    // ************************************************
    // Frame tasks
    // ************************************************
    // Checker verdicts follow the last byte, so the latched count is the full frame
    task automatic rx_frame(input int n, input logic [1:0] crc);
        @(posedge clk) rx_sfd_seen <= 1'b1;
        repeat (n)
        begin
            @(posedge clk) rx_sfd_seen <= 1'b0;
            rx_byte_stb <= 1'b1;
        end
        @(posedge clk) rx_byte_stb <= 1'b0;
        {crc8_good, crc32_good} <= crc;
        @(posedge clk) {crc8_good, crc32_good} <= 2'h0;
        rx_frame_end <= 1'b1;
        @(posedge clk) rx_frame_end <= 1'b0;
    endtask
    task automatic tx_frame(input int n, input int c);
        @(posedge clk) tx_sfd_sent <= 1'b1;
        repeat (n)
        begin
            @(posedge clk) tx_sfd_sent <= 1'b0;
            tx_byte_stb <= 1'b1;
        end
        repeat (c) @(posedge clk) tx_byte_is_crc <= 1'b1;
        @(posedge clk) {tx_byte_stb, tx_byte_is_crc} <= 2'h0;
        tx_frame_end <= 1'b1;
        @(posedge clk) tx_frame_end <= 1'b0;
    endtask
    task automatic pop(input int n);
        repeat (n) @(posedge clk) rx_queue_pop <= 1'b1;
        @(posedge clk) rx_queue_pop <= 1'b0;
    endtask
endmodule
`default_nettype wire
